//--- rtl/clockgen_consts.svh
`ifndef CLOCKGEN_CONSTS_SVH
`define CLOCKGEN_CONSTS_SVH

// register offsets on the 2-bit address port
`define OFS_LOOP_CTRL 2'h0
`define OFS_BW_CTRL 2'h1
`define OFS_PROG 2'h2

// loop_control_register fields
`define CTL_IRQ_EN_BIT 7
`define CTL_FLAG_BIT 6
`define CTL_PON_BIT 5
`define CTL_BSEL_BIT 4
`define CTL_UNUSED_VAL 4'hf

// bandwidth_control_register fields
`define BW_AUTO_BIT 7
`define BW_LOCK_BIT 6
`define BW_ACQ_BIT 5

// loop_multiplier_range_setting fields
`define PROG_MUL_HI 7
`define PROG_MUL_LO 4
`define PROG_RNG_HI 3
`define PROG_RNG_LO 0
`define PROG_RESET 8'h66
`define MUL_ZERO 4'h0
`define MUL_ONE 4'h1
`define RNG_ZERO 4'h0

// reset values of control bits
`define PON_RESET 1'b1
`define BSEL_RESET 1'b0
`define AUTO_RESET 1'b0

// source edges waited for on a source change, per clock
`define SW_EDGES 2'h3

// synchroniser lanes
`define SYNC_W 4
`define SYNC_XTAL 0
`define SYNC_VCO 1
`define SYNC_LOCK 2
`define SYNC_TRACK 3

`endif

//--- rtl/clockgen_pkg.sv
package clockgen_pkg;

    typedef enum logic [1:0] {
        sw_run = 2'b01,
        sw_hold = 2'b10
    } switch_state_t;

    typedef logic [7:0] reg_byte_t;

endpackage : clockgen_pkg

//--- rtl/clksel_if.sv
`timescale 1ns/1ns
`default_nettype none

interface clksel_if;
    logic sel_vco;
    logic xtal_edge;
    logic vco_edge;
    logic base_clk;
    logic switching;

    modport ctl (
        output sel_vco,
        output xtal_edge,
        output vco_edge,
        input base_clk,
        input switching
    );

    modport sw (
        input sel_vco,
        input xtal_edge,
        input vco_edge,
        output base_clk,
        output switching
    );
endinterface : clksel_if

`default_nettype wire

//--- rtl/clock_source_switch.sv
`timescale 1ns/1ns
`default_nettype none
`include "clockgen_consts.svh"

module clock_source_switch
    import clockgen_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    clksel_if.sw cs
);

    switch_state_t state_q, state_d;
    logic active_vco_q, active_vco_d;
    logic [1:0] xcnt_q, xcnt_d;
    logic [1:0] vcnt_q, vcnt_d;
    logic out_q, out_d;
    logic src_edge;

    ////////////////////////////////////////////////////////////////////////
    assign src_edge = active_vco_q ? cs.vco_edge : cs.xtal_edge;

    always_comb
    begin
        state_d = state_q;
        active_vco_d = active_vco_q;
        xcnt_d = xcnt_q;
        vcnt_d = vcnt_q;
        out_d = out_q;
        case (state_q)
            sw_run:
            begin
                if (cs.sel_vco != active_vco_q)
                begin
                    state_d = sw_hold;
                    xcnt_d = 2'h0;
                    vcnt_d = 2'h0;
                end
                else if (src_edge)
                begin
                    out_d = ~out_q;
                end
            end
            sw_hold:
            begin
                // output frozen while both clocks are counted
                if (cs.xtal_edge && xcnt_q != `SW_EDGES)
                begin
                    xcnt_d = xcnt_q + 2'h1;
                end
                if (cs.vco_edge && vcnt_q != `SW_EDGES)
                begin
                    vcnt_d = vcnt_q + 2'h1;
                end
                if (xcnt_q == `SW_EDGES && vcnt_q == `SW_EDGES)
                begin
                    active_vco_d = cs.sel_vco;
                    state_d = sw_run;
                end
            end
            default:
            begin
                state_d = sw_run;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= sw_run;
            active_vco_q <= 1'b0;
            xcnt_q <= 2'h0;
            vcnt_q <= 2'h0;
            out_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            active_vco_q <= active_vco_d;
            xcnt_q <= xcnt_d;
            vcnt_q <= vcnt_d;
            out_q <= out_d;
        end
    end

    assign cs.base_clk = out_q;
    assign cs.switching = (state_q == sw_hold);

    ////////////////////////////////////////////////////////////////////////
    property p_hold_static;
        @(posedge mclk) disable iff (!arst_n)
        (state_q == sw_hold) |=> $stable(out_q);
    endproperty
    a_hold_static: assert property (p_hold_static)
        else $error("base clock moved during source change");

    property p_divide;
        @(posedge mclk) disable iff (!arst_n)
        (state_q == sw_run && cs.sel_vco == active_vco_q && src_edge) |=> $changed(out_q);
    endproperty
    a_divide: assert property (p_divide)
        else $error("base clock missed a source edge");

    property p_switch_wait;
        @(posedge mclk) disable iff (!arst_n)
        $rose(state_q == sw_hold) |-> (state_q == sw_hold) [*3];
    endproperty
    a_switch_wait: assert property (p_switch_wait)
        else $error("source change ended too early");

    c_switch: cover property (@(posedge mclk) disable iff (!arst_n)
        (state_q == sw_hold) ##1 (state_q == sw_run));
endmodule : clock_source_switch

`default_nettype wire

//--- rtl/pll_base_clock_control.sv
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "clockgen_consts.svh"

module pll_base_clock_control
    import clockgen_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [1:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    input wire logic crystal_clock,
    input wire logic vco_clock,
    input wire logic lock_detect_in,
    input wire logic tracking_detect_in,
    input wire logic oscillator_enable_in,
    output logic base_clock_out,
    output logic clockgen_interrupt,
    output logic loop_enable,
    output logic [3:0] feedback_multiplier,
    output logic [3:0] range_multiplier,
    output logic tracking_mode
);

    logic [`SYNC_W-1:0] pins;
    logic [`SYNC_W-1:0] s1_q, s2_q, s3_q;

    reg_byte_t prog_q, prog_d;
    logic pon_q, pon_d;
    logic bsel_q, bsel_d;
    logic ie_q, ie_d;
    logic flag_q, flag_d;
    logic auto_q, auto_d;
    logic acq_man_q, acq_man_d;
    reg_byte_t rd_q, rd_d;
    logic irq_q, irq_d;
    logic len_q, len_d;
    logic [3:0] mul_q, mul_d;
    logic [3:0] rng_q, rng_d;
    logic trk_q, trk_d;

    logic wr_ctl, wr_bw, wr_prog, rd_ctl;
    logic [3:0] mul_field, rng_field;
    logic lock_s, track_s, lock_toggle;
    logic pon_req, bsel_req, pon_change;

    clksel_if cs ();

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers; third stage only feeds edge detection
    assign pins = {tracking_detect_in, lock_detect_in, vco_clock, crystal_clock};

    genvar gi;
    generate
        for (gi = 0; gi < `SYNC_W; gi = gi + 1)
        begin : g_sync
            always_ff @(posedge mclk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                    s3_q[gi] <= 1'b0;
                end
                else
                begin
                    s1_q[gi] <= pins[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                end
            end
        end
    endgenerate

    assign lock_s = s2_q[`SYNC_LOCK];
    assign track_s = s2_q[`SYNC_TRACK];
    assign lock_toggle = s2_q[`SYNC_LOCK] ^ s3_q[`SYNC_LOCK];

    ////////////////////////////////////////////////////////////////////////
    // register decode
    assign wr_ctl = wr_en && (addr == `OFS_LOOP_CTRL);
    assign wr_bw = wr_en && (addr == `OFS_BW_CTRL);
    assign wr_prog = wr_en && (addr == `OFS_PROG);
    assign rd_ctl = rd_en && (addr == `OFS_LOOP_CTRL);

    assign mul_field = prog_q[`PROG_MUL_HI:`PROG_MUL_LO];
    assign rng_field = prog_q[`PROG_RNG_HI:`PROG_RNG_LO];

    assign pon_req = wr_data[`CTL_PON_BIT];
    assign bsel_req = wr_data[`CTL_BSEL_BIT];
    assign pon_change = pon_req != pon_q;

    always_comb
    begin
        prog_d = prog_q;
        pon_d = pon_q;
        bsel_d = bsel_q;
        ie_d = ie_q;
        auto_d = auto_q;
        acq_man_d = acq_man_q;
        // frozen while the loop is powered
        if (wr_prog && !pon_q)
        begin
            prog_d = wr_data;
        end
        if (wr_ctl)
        begin
            // power bit locked on while vco drives the base clock
            pon_d = bsel_q ? 1'b1 : pon_req;
            // a power change wins; select waits for a second write
            if (!pon_change)
            begin
                bsel_d = bsel_req && pon_q;
            end
            ie_d = wr_data[`CTL_IRQ_EN_BIT];
        end
        if (wr_bw)
        begin
            auto_d = wr_data[`BW_AUTO_BIT];
            // acq bit is read-only in automatic mode; manual value kept
            if (!auto_q)
            begin
                acq_man_d = wr_data[`BW_ACQ_BIT];
            end
        end
        // zero range or power off keeps the crystal selected
        if (rng_field == `RNG_ZERO || !pon_q)
        begin
            bsel_d = 1'b0;
        end
        if (!auto_d)
        begin
            ie_d = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // lock change flag; a set in the clearing cycle survives
    always_comb
    begin
        flag_d = flag_q;
        if (rd_ctl)
        begin
            flag_d = 1'b0;
        end
        if (auto_q && lock_toggle)
        begin
            flag_d = 1'b1;
        end
        if (!auto_q)
        begin
            flag_d = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs and read data
    always_comb
    begin
        rd_d = 8'h00;
        case (addr)
            `OFS_LOOP_CTRL:
                rd_d = {ie_q, flag_q && auto_q, pon_q, bsel_q, `CTL_UNUSED_VAL};
            `OFS_BW_CTRL:
                rd_d = {auto_q, lock_s && auto_q, auto_q ? track_s : acq_man_q, 5'h00};
            `OFS_PROG:
                rd_d = prog_q;
            default:
                rd_d = 8'h00;
        endcase
        if (!rd_en)
        begin
            rd_d = 8'h00;
        end
        irq_d = flag_q && ie_q;
        // loop and oscillator only with enable from the integration logic
        len_d = pon_q && (rng_field != `RNG_ZERO) && oscillator_enable_in;
        mul_d = (mul_field == `MUL_ZERO) ? `MUL_ONE : mul_field;
        rng_d = rng_field;
        trk_d = auto_q ? track_s : acq_man_q;
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prog_q <= `PROG_RESET;
            pon_q <= `PON_RESET;
            bsel_q <= `BSEL_RESET;
            auto_q <= `AUTO_RESET;
            ie_q <= 1'b0;
            flag_q <= 1'b0;
            acq_man_q <= 1'b0;
            rd_q <= 8'h00;
            irq_q <= 1'b0;
            len_q <= 1'b0;
            mul_q <= 4'h0;
            rng_q <= 4'h0;
            trk_q <= 1'b0;
        end
        else
        begin
            prog_q <= prog_d;
            pon_q <= pon_d;
            bsel_q <= bsel_d;
            auto_q <= auto_d;
            ie_q <= ie_d;
            flag_q <= flag_d;
            acq_man_q <= acq_man_d;
            rd_q <= rd_d;
            irq_q <= irq_d;
            len_q <= len_d;
            mul_q <= mul_d;
            rng_q <= rng_d;
            trk_q <= trk_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // base clock selector; the divider flop sits inside the switch
    assign cs.sel_vco = bsel_q;
    assign cs.xtal_edge = s2_q[`SYNC_XTAL] && !s3_q[`SYNC_XTAL];
    assign cs.vco_edge = s2_q[`SYNC_VCO] && !s3_q[`SYNC_VCO];

    clock_source_switch clock_source_switch_i (
        .mclk(mclk),
        .arst_n(arst_n),
        .cs(cs)
    );

    assign base_clock_out = cs.base_clk;
    assign rd_data = rd_q;
    assign clockgen_interrupt = irq_q;
    assign loop_enable = len_q;
    assign feedback_multiplier = mul_q;
    assign range_multiplier = rng_q;
    assign tracking_mode = trk_q;

    ////////////////////////////////////////////////////////////////////////
    property p_pon_forced;
        @(posedge mclk) disable iff (!arst_n)
        bsel_q |-> pon_q;
    endproperty
    a_pon_forced: assert property (p_pon_forced)
        else $error("vco selected with loop off");

    property p_bsel_gate;
        @(posedge mclk) disable iff (!arst_n)
        (!pon_q || rng_field == `RNG_ZERO) |=> !bsel_q;
    endproperty
    a_bsel_gate: assert property (p_bsel_gate)
        else $error("select set while loop off or range zero");

    property p_ie_manual;
        @(posedge mclk) disable iff (!arst_n)
        !auto_q |-> !ie_q;
    endproperty
    a_ie_manual: assert property (p_ie_manual)
        else $error("irq enable set in manual mode");

    property p_read_clears;
        @(posedge mclk) disable iff (!arst_n)
        (rd_ctl && !lock_toggle) |=> !flag_q;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("flag survived a control read");

    property p_flag_sets;
        @(posedge mclk) disable iff (!arst_n)
        (auto_q && lock_toggle) |=> flag_q ##1 (!ie_q || clockgen_interrupt);
    endproperty
    a_flag_sets: assert property (p_flag_sets)
        else $error("lock toggle lost");

    property p_prog_frozen;
        @(posedge mclk) disable iff (!arst_n)
        (wr_prog && pon_q) |=> $stable(prog_q);
    endproperty
    a_prog_frozen: assert property (p_prog_frozen)
        else $error("programming changed with loop on");

    property p_one_change;
        @(posedge mclk) disable iff (!arst_n)
        wr_ctl |=> !($changed(pon_q) && $changed(bsel_q));
    endproperty
    a_one_change: assert property (p_one_change)
        else $error("power and select changed together");

    property p_mul_zero;
        @(posedge mclk) disable iff (!arst_n)
        (mul_field == `MUL_ZERO) |=> (feedback_multiplier == `MUL_ONE);
    endproperty
    a_mul_zero: assert property (p_mul_zero)
        else $error("zero multiplier not read as one");

    property p_rng_zero;
        @(posedge mclk) disable iff (!arst_n)
        (rng_field == `RNG_ZERO) |=> !loop_enable;
    endproperty
    a_rng_zero: assert property (p_rng_zero)
        else $error("loop enabled with zero range");

    property p_manual_reads;
        @(posedge mclk) disable iff (!arst_n)
        (rd_en && addr == `OFS_BW_CTRL && !auto_q) |=> !rd_data[`BW_LOCK_BIT];
    endproperty
    a_manual_reads: assert property (p_manual_reads)
        else $error("lock read nonzero in manual mode");

    c_vco_select: cover property (@(posedge mclk) disable iff (!arst_n) $rose(bsel_q));
    c_irq: cover property (@(posedge mclk) disable iff (!arst_n) $rose(clockgen_interrupt));
    c_set_clear: cover property (@(posedge mclk) disable iff (!arst_n)
        rd_ctl && auto_q && lock_toggle);
endmodule : pll_base_clock_control

`default_nettype wire

//--- sim/base_clock_sink.sv
`timescale 1ns/1ns
`default_nettype none

module base_clock_sink (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic base_clock_out,
    input wire logic osc_req,
    output logic oscillator_enable_in,
    output logic [7:0] high_len,
    output logic [7:0] low_len,
    output logic [15:0] edge_cnt
);
    logic osc_q, osc_d;
    logic prev_q, prev_d;
    logic [7:0] run_q, run_d, high_q, high_d, low_q, low_d;
    logic [15:0] cnt_q, cnt_d;

    ////////////////////////////////////////////////////////////////////////////////
    // oscillator and loop run only while this level is high
    // half periods counted in mclk cycles, so the duty can be judged
    always_comb
    begin
        osc_d = osc_req;
        prev_d = base_clock_out;
        run_d = run_q + 8'h01;
        high_d = high_q;
        low_d = low_q;
        cnt_d = cnt_q;
        if (base_clock_out != prev_q)
        begin
            run_d = 8'h01;
            cnt_d = cnt_q + 16'h0001;
            if (prev_q)
                high_d = run_q;
            else
                low_d = run_q;
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            osc_q <= 1'b0;
            prev_q <= 1'b0;
            run_q <= 8'h00;
            high_q <= 8'h00;
            low_q <= 8'h00;
            cnt_q <= 16'h0000;
        end
        else
        begin
            osc_q <= osc_d;
            prev_q <= prev_d;
            run_q <= run_d;
            high_q <= high_d;
            low_q <= low_d;
            cnt_q <= cnt_d;
        end
    end

    assign oscillator_enable_in = osc_q;
    assign high_len = high_q;
    assign low_len = low_q;
    assign edge_cnt = cnt_q;
endmodule : base_clock_sink

`default_nettype wire

//--- sim/pll_base_clock_control_tb.sv
`timescale 1ns/1ns
`default_nettype none

module pll_base_clock_control_tb;
    import clockgen_pkg::*;

    logic mclk, arst_n, wr_en, rd_en, crystal_clock, vco_clock, lock_detect_in;
    logic tracking_detect_in, osc_req, rd_seen, b, t;
    logic [1:0] addr;
    reg_byte_t wr_data, rd_data, rb;
    logic base_clock_out, clockgen_interrupt, loop_enable, tracking_mode, oscillator_enable_in;
    logic [3:0] feedback_multiplier, range_multiplier;
    logic [7:0] high_len, low_len;
    logic [15:0] edge_cnt;
    int fail_count, n_compared, seed, i;
    reg_byte_t exp_q[$];

    pll_base_clock_control pll_base_clock_control_i (.mclk(mclk), .arst_n(arst_n),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .crystal_clock(crystal_clock), .vco_clock(vco_clock),
        .lock_detect_in(lock_detect_in), .tracking_detect_in(tracking_detect_in),
        .oscillator_enable_in(oscillator_enable_in), .base_clock_out(base_clock_out),
        .clockgen_interrupt(clockgen_interrupt), .loop_enable(loop_enable),
        .feedback_multiplier(feedback_multiplier), .range_multiplier(range_multiplier),
        .tracking_mode(tracking_mode));

    base_clock_sink base_clock_sink_i (.mclk(mclk), .arst_n(arst_n),
        .base_clock_out(base_clock_out), .osc_req(osc_req),
        .oscillator_enable_in(oscillator_enable_in), .high_len(high_len),
        .low_len(low_len), .edge_cnt(edge_cnt));

    ////////////////////////////////////////////////////////////////////////////////
    // unrelated periods so the source edges drift against mclk
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    initial
    begin
        crystal_clock = 1'b0;
        #3;
        forever #17 crystal_clock = ~crystal_clock;
    end

    initial
    begin
        vco_clock = 1'b0;
        #1;
        forever #13 vco_clock = ~vco_clock;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic mism(input string m);
        fail_count++;
        $display("MISMATCH %0t %s", $time, m);
    endtask : mism

    task automatic chk_byte(input reg_byte_t got, input reg_byte_t exp);
        n_compared++;
        if (got !== exp)
            mism($sformatf("byte got %h want %h", got, exp));
    endtask : chk_byte

    task automatic chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp)
            mism($sformatf("bit got %b want %b", got, exp));
    endtask : chk_bit

    task automatic chk_span(input int got, input int lo, input int hi);
        n_compared++;
        if (got < lo || got > hi)
            mism($sformatf("half period %0d outside %0d..%0d", got, lo, hi));
    endtask : chk_span

    task automatic wr(input logic [1:0] a, input reg_byte_t d);
        @(posedge mclk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [1:0] a, input reg_byte_t exp);
        @(posedge mclk);
        rd_en <= 1'b1;
        addr <= a;
        exp_q.push_back(exp);
        @(posedge mclk);
        rd_en <= 1'b0;
    endtask : rd

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask : settle

    // waits four base edges so the measured halves belong to the current source
    task automatic base_span(input int lo, input int hi);
        int c;
        c = edge_cnt;
        for (int k = 0; k < 200 && edge_cnt < c + 4; k++) @(negedge mclk);
        chk_span(high_len, lo, hi);
        chk_span(low_len, lo, hi);
    endtask : base_span

    task automatic finish_test();
        if (fail_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////////////////
    // read data stands only in the cycle after the strobe
    always @(posedge mclk) rd_seen <= rd_en;

    always @(negedge mclk)
        if (rd_seen)
            chk_byte(rd_data, exp_q.pop_front());

    initial
    begin
        repeat (20000) @(posedge mclk);
        mism("timeout");
        finish_test();
    end

    initial
    begin
        seed = 32'hef47;
        fail_count = 0;
        n_compared = 0;
        arst_n = 1'b0;
        addr = 2'h0;
        wr_data = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        rd_seen = 1'b0;
        lock_detect_in = 1'b0;
        tracking_detect_in = 1'b0;
        osc_req = 1'b1;
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        settle(2);
        chk_bit(loop_enable, 1'b1);
        chk_byte({4'h0, feedback_multiplier}, 8'h06);
        chk_byte({4'h0, range_multiplier}, 8'h06);
        chk_bit(tracking_mode, 1'b0);
        rd(2'h0, 8'h2f);
        rd(2'h1, 8'h00);
        rb = reg_byte_t'($random(seed));
        wr(2'h2, rb);
        rd(2'h2, 8'h66);
        base_span(8, 9);
        wr(2'h0, 8'h10);
        rd(2'h0, 8'h0f);
        wr(2'h2, 8'h05);
        rd(2'h2, 8'h05);
        settle(2);
        chk_byte({4'h0, feedback_multiplier}, 8'h01);
        chk_byte({4'h0, range_multiplier}, 8'h05);
        wr(2'h0, 8'h10);
        rd(2'h0, 8'h0f);
        wr(2'h2, 8'h30);
        wr(2'h0, 8'h20);
        wr(2'h0, 8'h30);
        rd(2'h0, 8'h2f);
        settle(2);
        chk_bit(loop_enable, 1'b0);
        chk_byte({4'h0, feedback_multiplier}, 8'h03);
        // loop off, new setting, then power and select in two writes
        wr(2'h0, 8'h00);
        wr(2'h2, 8'h34);
        wr(2'h0, 8'h20);
        wr(2'h0, 8'h30);
        settle(2);
        b = base_clock_out;
        for (i = 0; i < 8; i++)
        begin
            @(negedge mclk);
            chk_bit(base_clock_out, b);
        end
        for (i = 0; i < 100 && base_clock_out === b; i++) @(negedge mclk);
        chk_bit(base_clock_out, ~b);
        base_span(6, 7);
        rd(2'h0, 8'h3f);
        wr(2'h0, 8'h10);
        rd(2'h0, 8'h3f);
        wr(2'h0, 8'hb0);
        rd(2'h0, 8'h3f);
        wr(2'h1, 8'h80);
        // acq write refused in automatic mode; the later manual read shows it
        wr(2'h1, 8'ha0);
        wr(2'h0, 8'hb0);
        rd(2'h0, 8'hbf);
        t = 1'($random(seed));
        tracking_detect_in <= t;
        lock_detect_in <= 1'b1;
        for (i = 0; i < 10 && clockgen_interrupt !== 1'b1; i++) @(negedge mclk);
        chk_bit(clockgen_interrupt, 1'b1);
        chk_bit(tracking_mode, t);
        rd(2'h1, {2'b11, t, 5'h00});
        rd(2'h0, 8'hff);
        rd(2'h0, 8'hbf);
        settle(2);
        chk_bit(clockgen_interrupt, 1'b0);
        wr(2'h1, 8'h00);
        lock_detect_in <= 1'b0;
        settle(6);
        chk_bit(clockgen_interrupt, 1'b0);
        rd(2'h0, 8'h3f);
        rd(2'h1, 8'h00);
        wr(2'h1, 8'h20);
        rd(2'h1, 8'h20);
        settle(2);
        chk_bit(tracking_mode, 1'b1);
        wr(2'h3, 8'hff);
        rd(2'h3, 8'h00);
        @(posedge mclk);
        osc_req <= 1'b0;
        settle(3);
        chk_bit(loop_enable, 1'b0);
        finish_test();
    end
endmodule : pll_base_clock_control_tb

`default_nettype wire
